// >>> hw/rru_pkg.sv
// rru_pkg: shared constants of the refresh request unit and its partner
// assumes: one 125 MHz clock, 16-bit registers on a 32-bit apb data path
`default_nettype none
package rru_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] RRU_IDX_BASE = 16'hf4a0;
    localparam logic [15:0] RRU_IDX_RELOAD = 16'hf4a2;
    localparam logic [15:0] RRU_IDX_CONTROL = 16'hf4a4;
    localparam logic [15:0] RRU_IDX_ROW = 16'hf4a6;
    localparam int RRU_APB_AW = 18;
    localparam logic [17:0] RRU_ADDR_BASE = {RRU_IDX_BASE, 2'b00};
    localparam logic [17:0] RRU_ADDR_RELOAD = {RRU_IDX_RELOAD, 2'b00};
    localparam logic [17:0] RRU_ADDR_CONTROL = {RRU_IDX_CONTROL, 2'b00};
    localparam logic [17:0] RRU_ADDR_ROW = {RRU_IDX_ROW, 2'b00};
    // field layout
    localparam int RRU_ENABLE_BIT = 15;
    localparam int RRU_COUNT_W = 10;
    localparam int RRU_UPPER_W = 12;
    localparam int RRU_LOWER_W = 13;
    localparam int RRU_SHIFT_W = 7;
    localparam int RRU_BIN_W = 6;
    // reset values
    localparam logic [15:0] RRU_RST_BASE = 16'h0000;
    localparam logic [15:0] RRU_RST_RELOAD = 16'h0000;
    localparam logic [15:0] RRU_RST_CONTROL = 16'h0000;
    localparam logic [15:0] RRU_RST_ROW = 16'h00ff;
    localparam logic [6:0] RRU_SHIFT_START = 7'h7f;
    // timing counts in clock cycles
    localparam int RRU_CYCLE_CLKS = 4;
    localparam int RRU_RAS_CLKS = 2;
endpackage
`default_nettype wire

// >>> hw/rru_if.sv
// rru_if: link between the refresh unit and the external memory controller
// assumes: both ends share one clock; no tristate on this link
`default_nettype none
interface rru_if;
    logic refresh_n;
    logic mem_rd_n;
    logic low_byte_enable_n;
    logic high_byte_enable_n;
    logic [25:1] addr;
    logic external_bus_grant;
    logic hold_req;
    logic ras_n;

    modport dev (
        output refresh_n,
        output mem_rd_n,
        output low_byte_enable_n,
        output high_byte_enable_n,
        output addr,
        output external_bus_grant,
        input hold_req,
        input ras_n
    );
    modport mem (
        input refresh_n,
        input mem_rd_n,
        input low_byte_enable_n,
        input high_byte_enable_n,
        input addr,
        input external_bus_grant,
        output hold_req,
        output ras_n
    );
endinterface
`default_nettype wire

// >>> hw/rru_addr_counter.sv
// rru_addr_counter: 13-bit refresh row counter, shift register plus binary
// assumes: step and load are single-cycle strobes from the refresh unit
`default_nettype none
module rru_addr_counter
    import rru_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic step_in,
    input wire logic load_in,
    input wire logic [12:0] load_val_in,
    output logic [12:0] value_out
);
    logic [RRU_SHIFT_W-1:0] shift_q;
    logic [RRU_BIN_W-1:0] bin_q;
    logic [RRU_SHIFT_W-1:0] next_shift;
    logic feedback;
    logic wrap;

    assign feedback = shift_q[6] ^ shift_q[5] ^ (shift_q[5:0] == 6'h00);
    assign next_shift = {shift_q[5:0], feedback};
    // binary part steps per full lap
    assign wrap = (next_shift == RRU_SHIFT_START);
    assign value_out = {bin_q, shift_q};

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            shift_q <= RRU_RST_ROW[7:1];
            bin_q <= RRU_RST_ROW[13:8];
        end
        else if (load_in)
        begin
            shift_q <= load_val_in[6:0];
            bin_q <= load_val_in[12:7];
        end
        else if (step_in)
        begin
            shift_q <= next_shift;
            bin_q <= wrap ? bin_q + 6'h01 : bin_q;
        end
    end
endmodule // rru_addr_counter
`default_nettype wire

// >>> hw/rru_refresh_unit.sv
// rru_refresh_unit: periodic refresh requester with apb register access
// assumes: apb master on CLK_IN; memory controller and bus master on LINK
// Functional notes
// - at one, time out and reload
// - request bus, start only when granted
// - strobe low, read cycle, enables off
// - partner strobes row on refresh
// - strobe released, wait next timeout
// - runs until reprogram, reset, powerdown
// - ten-bit reload, upper reserved, resets zero
// - control bit fifteen enables unit
// - low ten control bits read count
// - base supplies upper twelve address bits
// - row register bits 13:1, bit0 one
// - both byte enables high during refresh
// - refresh beats every other requester
// - withdraw external grant on request
// - partner drops hold, refresh waits
// - software keeps reload at least eight
// - software derives reload from period
// - row address steps per refresh
// - partner spots refresh by strobe/enables
// - ignore timeout while request pending
// - seven-bit shift plus six-bit binary
// - counter loads and decrements each clock
//
// The implementer's own choice: the APB interface to the registers.
`default_nettype none
module rru_refresh_unit
    import rru_pkg::*;
#(
    parameter int CYCLE_CLKS = RRU_CYCLE_CLKS
)
(
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic POWERDOWN_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [RRU_APB_AW-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    rru_if.dev LINK
);
    typedef enum logic [1:0] {RRU_IDLE, RRU_REQ, RRU_CYCLE} rru_state_t;

    rru_state_t state;
    logic [RRU_UPPER_W-1:0] base;
    logic [RRU_COUNT_W-1:0] reload;
    logic enable;
    logic [RRU_COUNT_W-1:0] count;
    logic [3:0] cyc_cnt;
    logic [12:0] row_value;
    logic [31:0] next_prdata;
    logic sel_base;
    logic sel_reload;
    logic sel_control;
    logic sel_row;
    logic mapped;
    logic apb_setup;
    logic apb_write;
    logic timeout;
    logic ack;
    logic cycle_last;
    logic next_ext_grant;
    logic ext_owner;

    // apb decode; no wait state, read data comes from a flop loaded in setup
    assign sel_base = (PADDR_IN == RRU_ADDR_BASE);
    assign sel_reload = (PADDR_IN == RRU_ADDR_RELOAD);
    assign sel_control = (PADDR_IN == RRU_ADDR_CONTROL);
    assign sel_row = (PADDR_IN == RRU_ADDR_ROW);
    assign mapped = sel_base | sel_reload | sel_control | sel_row;
    assign apb_setup = PSEL_IN & ~PENABLE_IN;
    assign apb_write = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN & mapped;

    // count visible, enable in bit 15
    // row bits from counter, bit0 one
    assign next_prdata = sel_base ? {20'h00000, base} :
                         sel_reload ? {22'h000000, reload} :
                         sel_control ? {16'h0000, enable, 5'h00, count} :
                         sel_row ? {18'h00000, row_value, 1'b1} : 32'h00000000;

    // timeout at one, also held off by powerdown
    assign timeout = enable & ~POWERDOWN_IN & (count <= 10'h001);
    // refresh owns bus once others let go
    // wait until external master dropped hold
    // a hold never granted must not stall refresh, or both sides wait forever
    assign ack = (state == RRU_REQ) & ~LINK.external_bus_grant & ~(LINK.hold_req & ext_owner);
    assign cycle_last = (state == RRU_CYCLE) & (cyc_cnt == 4'(CYCLE_CLKS - 1));
    // external grant withdrawn while refresh wants bus
    assign next_ext_grant = LINK.hold_req & (state == RRU_IDLE) & ~timeout;

    // bus stays taken until granted master lets go
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            ext_owner <= 1'b0;
        end
        else
        begin
            ext_owner <= LINK.external_bus_grant | (ext_owner & LINK.hold_req);
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            PRDATA_OUT <= 32'h00000000;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end
        else
        begin
            PRDATA_OUT <= apb_setup ? next_prdata : PRDATA_OUT;
            PREADY_OUT <= apb_setup;
            PSLVERR_OUT <= apb_setup & ~mapped;
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            base <= RRU_RST_BASE[RRU_UPPER_W-1:0];
            reload <= RRU_RST_RELOAD[RRU_COUNT_W-1:0];
            enable <= RRU_RST_CONTROL[RRU_ENABLE_BIT];
        end
        else if (apb_write)
        begin
            base <= sel_base ? PWDATA_IN[RRU_UPPER_W-1:0] : base;
            reload <= sel_reload ? PWDATA_IN[RRU_COUNT_W-1:0] : reload;
            enable <= sel_control ? PWDATA_IN[RRU_ENABLE_BIT] : enable;
        end
    end

    // load while off, decrement each clock while on unless powered down
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            count <= RRU_RST_CONTROL[RRU_COUNT_W-1:0];
        end
        else if (!enable)
        begin
            count <= reload;
        end
        else if (timeout)
        begin
            count <= reload;
        end
        else if (!POWERDOWN_IN)
        begin
            count <= count - 10'h001;
        end
    end

    // row advances at end of each refresh
    // counter split into shift and binary parts
    rru_addr_counter u_row (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .step_in(cycle_last),
        .load_in(apb_write & sel_row),
        .load_val_in(PWDATA_IN[13:1]),
        .value_out(row_value)
    );

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            state <= RRU_IDLE;
            cyc_cnt <= 4'h0;
        end
        else
        begin
            case (state)
                RRU_IDLE:
                begin
                    if (timeout)
                    begin
                        state <= RRU_REQ;
                    end
                end
                RRU_REQ:
                begin
                    if (ack)
                    begin
                        state <= RRU_CYCLE;
                        cyc_cnt <= 4'h0;
                    end
                end
                RRU_CYCLE:
                begin
                    if (cycle_last)
                    begin
                        state <= RRU_IDLE;
                    end
                    else
                    begin
                        cyc_cnt <= cyc_cnt + 4'h1;
                    end
                end
                default:
                begin
                    state <= RRU_IDLE;
                end
            endcase
        end
    end

    // link outputs all from flops
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            LINK.refresh_n <= 1'b1;
            LINK.mem_rd_n <= 1'b1;
            LINK.low_byte_enable_n <= 1'b1;
            LINK.high_byte_enable_n <= 1'b1;
            LINK.addr <= 25'h0000000;
            LINK.external_bus_grant <= 1'b0;
        end
        else
        begin
            LINK.external_bus_grant <= next_ext_grant;
            // byte enables never driven active: this bus only refreshes
            // both enables stay high
            LINK.low_byte_enable_n <= 1'b1;
            LINK.high_byte_enable_n <= 1'b1;
            if (ack)
            begin
                // strobe and read cycle with refresh address
                LINK.refresh_n <= 1'b0;
                LINK.mem_rd_n <= 1'b0;
                LINK.addr <= {base, row_value};
            end
            else if (cycle_last)
            begin
                LINK.refresh_n <= 1'b1;
                LINK.mem_rd_n <= 1'b1;
            end
        end
    end
endmodule // rru_refresh_unit
`default_nettype wire

// >>> hw/rru_mem_ctrl.sv
// rru_mem_ctrl: external memory controller and hold master facing the unit
// assumes: same clock as the refresh unit; user hold request is synchronous
`default_nettype none
module rru_mem_ctrl
    import rru_pkg::*;
#(
    parameter int RAS_CLKS = RRU_RAS_CLKS
)
(
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic HOLD_REQ_IN,
    output logic HOLD_GRANT_OUT,
    output logic [25:1] ROW_ADDR_OUT,
    output logic REFRESH_DONE_OUT,
    rru_if.mem LINK
);
    logic seen;
    logic seen_d;
    logic granted_d;
    logic backoff;
    logic [3:0] ras_cnt;
    logic ras_active;
    logic start;
    logic ras_last;

    // refresh seen by strobe or by both enables off on a read
    assign seen = ~LINK.refresh_n |
                  (LINK.low_byte_enable_n & LINK.high_byte_enable_n & ~LINK.mem_rd_n);
    assign start = seen & ~seen_d;
    assign ras_active = (ras_cnt != 4'h0);
    assign ras_last = (ras_cnt == 4'h1);

    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            seen_d <= 1'b0;
            ras_cnt <= 4'h0;
            LINK.ras_n <= 1'b1;
            ROW_ADDR_OUT <= 25'h0000000;
            REFRESH_DONE_OUT <= 1'b0;
        end
        else
        begin
            seen_d <= seen;
            REFRESH_DONE_OUT <= ras_last;
            if (start)
            begin
                ras_cnt <= 4'(RAS_CLKS);
                LINK.ras_n <= 1'b0;
                ROW_ADDR_OUT <= LINK.addr;
            end
            else if (ras_active)
            begin
                ras_cnt <= ras_cnt - 4'h1;
                LINK.ras_n <= ras_last;
            end
        end
    end

    // drop hold after grant withdrawn, until refresh ends
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            granted_d <= 1'b0;
            backoff <= 1'b0;
            LINK.hold_req <= 1'b0;
            HOLD_GRANT_OUT <= 1'b0;
        end
        else
        begin
            granted_d <= LINK.external_bus_grant;
            HOLD_GRANT_OUT <= LINK.external_bus_grant;
            if (granted_d & ~LINK.external_bus_grant & LINK.hold_req)
            begin
                backoff <= 1'b1;
                LINK.hold_req <= 1'b0;
            end
            else if (seen_d & ~seen)
            begin
                backoff <= 1'b0;
                LINK.hold_req <= HOLD_REQ_IN;
            end
            else
            begin
                LINK.hold_req <= HOLD_REQ_IN & ~backoff;
            end
        end
    end
endmodule // rru_mem_ctrl
`default_nettype wire

// >>> dv/rru_asserts.sv
// rru_asserts: timing checks on the link between refresh unit and memory end
// assumes: one clock, instantiated beside the link interface
`default_nettype none
module rru_asserts #(
    parameter int CYCLE_CLKS = 4
)
(
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic refresh_n,
    input wire logic mem_rd_n,
    input wire logic low_byte_enable_n,
    input wire logic high_byte_enable_n,
    input wire logic [25:1] addr,
    input wire logic external_bus_grant,
    input wire logic hold_req,
    input wire logic ras_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned low_cnt;
    logic [12:0] last_row;
    logic seen;
    logic owned;
    // counter, not repetition: strobe width is a parameter
    always_ff @(posedge CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            low_cnt <= 0;
            last_row <= '0;
            seen <= 1'b0;
            owned <= 1'b0;
        end
        else
        begin
            low_cnt <= refresh_n ? 0 : low_cnt + 1;
            // external master owns the bus from grant until it drops hold
            owned <= external_bus_grant | (owned & hold_req);
            if (!refresh_n)
            begin
                last_row <= addr[13:1];
                seen <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    a_read_with_strobe: assert property (mem_rd_n == refresh_n)
        else $error("read strobe differs from refresh strobe");
    a_enables_off: assert property (!refresh_n |-> low_byte_enable_n && high_byte_enable_n)
        else $error("byte enable active in refresh");
    a_strobe_width: assert property ($rose(refresh_n) |-> low_cnt == CYCLE_CLKS)
        else $error("refresh strobe width wrong");
    a_grant_off: assert property (!refresh_n |-> !external_bus_grant)
        else $error("grant held during refresh");
    a_start_owned: assert property ($fell(refresh_n) |-> !($past(hold_req) && $past(owned)) && !$past(external_bus_grant))
        else $error("refresh began without bus");
    a_addr_held: assert property (!refresh_n && !$past(refresh_n) |-> $stable(addr))
        else $error("address moved in refresh");
    a_row_steps: assert property ($fell(refresh_n) && seen |-> addr[13:1] != last_row)
        else $error("row address did not step");
    a_ras_follows: assert property ($fell(refresh_n) |-> ##[1:3] !ras_n)
        else $error("row strobe missing");
    a_hold_dropped: assert property ($fell(external_bus_grant) |-> ##[0:2] !hold_req)
        else $error("hold request kept after grant loss");
    a_grant_asked: assert property ($rose(external_bus_grant) |-> $past(hold_req))
        else $error("grant without request");
    c_refresh: cover property ($fell(refresh_n));
    c_grant_taken: cover property ($fell(external_bus_grant) ##[1:4] $fell(refresh_n));
    c_grant_back: cover property ($rose(refresh_n) ##[1:6] $rose(external_bus_grant));
endmodule // rru_asserts
`default_nettype wire

// >>> dv/tb_top.sv
// tb_top: both link ends joined, apb driven, refresh traffic observed
// assumes: 125 MHz clock, reload kept at 20 or more
`default_nettype none
module tb_top
    import rru_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, pdown, psel, pen, pwr, hold, pready, pslverr, hgrant, rdone, e;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, r, v;
    logic [25:1] rowaddr;
    logic [25:1] ref_q[$];
    int ref_t[$];
    int bad_count, n_compared, cyc, n_done, done_i, n;
    logic prev_ref;
    logic [9:0] rl;
    logic [15:0] base;
    logic [12:0] exp_row, w;
    logic [6:0] pl;
    rru_if lnk();
    rru_refresh_unit #(.CYCLE_CLKS(4)) u_rru_refresh_unit (.CLK_IN(clk), .RSTN_IN(rstn),
        .POWERDOWN_IN(pdown), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .LINK(lnk));
    rru_mem_ctrl #(.RAS_CLKS(2)) u_rru_mem_ctrl (.CLK_IN(clk), .RSTN_IN(rstn),
        .HOLD_REQ_IN(hold), .HOLD_GRANT_OUT(hgrant), .ROW_ADDR_OUT(rowaddr),
        .REFRESH_DONE_OUT(rdone), .LINK(lnk));
    rru_asserts #(.CYCLE_CLKS(4)) u_rru_asserts (.CLK_IN(clk), .RSTN_IN(rstn),
        .refresh_n(lnk.refresh_n), .mem_rd_n(lnk.mem_rd_n),
        .low_byte_enable_n(lnk.low_byte_enable_n), .high_byte_enable_n(lnk.high_byte_enable_n),
        .addr(lnk.addr), .external_bus_grant(lnk.external_bus_grant),
        .hold_req(lnk.hold_req), .ras_n(lnk.ras_n));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [12:0] next_row(input logic [12:0] q);
        logic [6:0] lo;
        lo = {q[5:0], q[6] ^ q[5] ^ (q[5:0] == 6'h00)};
        return {q[12:7] + {5'h00, lo == 7'h7f}, lo};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // ready and data read at the rising edge, before its updates land
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rd(input logic [17:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(r, exp);
    endtask
    task automatic chk_refs();
        while (done_i < ref_q.size())
        begin
            check({7'h0, ref_q[done_i]}, {7'h0, base[11:0], exp_row});
            exp_row = next_row(exp_row);
            done_i++;
        end
    endtask
    // sampled on the falling edge so design updates have landed
    always @(negedge clk)
    begin
        if (prev_ref === 1'b1 && lnk.refresh_n === 1'b0)
        begin
            ref_q.push_back(lnk.addr);
            ref_t.push_back(cyc);
        end
        prev_ref = lnk.refresh_n;
        if (rdone === 1'b1)
            n_done++;
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            summarize();
        end
    end
    initial
    begin
        {rstn, pdown, psel, pen, pwr, hold, paddr, pwdata} = '0;
        prev_ref = 1'b1;
        void'($urandom(32'h140b));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rd(RRU_ADDR_BASE, 32'h0);
        rd(RRU_ADDR_RELOAD, 32'h0);
        rd(RRU_ADDR_CONTROL, 32'h0);
        rd(RRU_ADDR_ROW, 32'h00ff);
        apb(1'b1, 18'h00010, 32'h1234);
        rd(18'h00010, 32'h0);
        check({31'h0, e}, 32'h1);
        $display("test reset values done");
        rl = 10'($urandom_range(40, 20));
        base = 16'($urandom);
        apb(1'b1, RRU_ADDR_BASE, {16'h0, base});
        apb(1'b1, RRU_ADDR_RELOAD, {16'h0, 6'($urandom), rl});
        apb(1'b1, RRU_ADDR_CONTROL, 32'h03ff);
        rd(RRU_ADDR_BASE, {20'h0, base[11:0]});
        rd(RRU_ADDR_RELOAD, {22'h0, rl});
        rd(RRU_ADDR_CONTROL, {22'h0, rl});
        $display("test field masks done");
        exp_row = 13'h007f;
        apb(1'b1, RRU_ADDR_CONTROL, 32'h8000);
        wait (ref_q.size() >= 5);
        chk_refs();
        for (int i = 1; i < 4; i++)
            check(32'(ref_t[i + 1] - ref_t[i]), {22'h0, rl});
        apb(1'b0, RRU_ADDR_CONTROL, 32'h0);
        check({31'h0, r[15] && r[9:0] >= 10'd1 && r[9:0] <= rl}, 32'h1);
        $display("test periodic refresh done");
        @(posedge clk);
        hold <= 1'b1;
        n = ref_q.size();
        wait (ref_q.size() >= n + 2);
        repeat (10) @(negedge clk);
        check({31'h0, hgrant}, 32'h1);
        chk_refs();
        @(posedge clk);
        hold <= 1'b0;
        $display("test hold preemption done");
        pdown <= 1'b1;
        apb(1'b0, RRU_ADDR_CONTROL, 32'h0);
        v = r;
        repeat (8) @(posedge clk);
        n = ref_q.size();
        repeat (3 * rl) @(posedge clk);
        rd(RRU_ADDR_CONTROL, v);
        check(32'(ref_q.size()), 32'(n));
        pdown <= 1'b0;
        $display("test powerdown done");
        apb(1'b1, RRU_ADDR_CONTROL, 32'h0);
        repeat (8) @(posedge clk);
        n = ref_q.size();
        repeat (3 * rl) @(posedge clk);
        check(32'(ref_q.size()), 32'(n));
        chk_refs();
        rd(RRU_ADDR_ROW, {18'h0, exp_row, 1'b1});
        check({7'h0, rowaddr}, {7'h0, ref_q[$]});
        check(32'(n_done), 32'(ref_q.size()));
        $display("test disable done");
        for (int i = 0; i < 128; i++)
        begin
            w = next_row({6'h0, 7'(i)});
            if (w[6:0] == 7'h7f)
                pl = 7'(i);
        end
        exp_row = {exp_row[12:7] + 6'h3, pl};
        apb(1'b1, RRU_ADDR_ROW, {18'h0, exp_row, 1'b0});
        apb(1'b1, RRU_ADDR_CONTROL, 32'h8000);
        n = ref_q.size();
        wait (ref_q.size() >= n + 2);
        chk_refs();
        apb(1'b1, RRU_ADDR_CONTROL, 32'h0);
        $display("test lap wrap done");
        summarize();
    end
endmodule // tb_top
`default_nettype wire
